/* design/ccr_regs.sv */
/*
 calibration register bank for converter channel 3, avalon-mm slave.
 assumes one clock, async active-low reset, 32-bit avalon-mm master.
*/
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ccr_params.svh"
module ccr_regs (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic [1:0]       avs_response,
   output logic [23:0]      offset_trim,
   output logic [23:0]      gain_trim
);
   import ccr_pkg::*;

   // *****************************
   // state
   // *****************************
   typedef struct packed {
      ccr_state_t  st;
      ccr_trim_t   trim;
      logic [31:0] rdata;
      logic [1:0]  resp;
      logic        wreq;
   } ccr_regs_state_t;

   ccr_regs_state_t s_r;
   ccr_regs_state_t s_nxt;
   logic            hit_ofs_hi;
   logic            hit_ofs_lo;
   logic            hit_gain_hi;
   logic            hit_gain_lo;
   logic            any_hit;

   ccr_decode u_dec (
      .address     (avs_address),
      .hit_ofs_hi  (hit_ofs_hi),
      .hit_ofs_lo  (hit_ofs_lo),
      .hit_gain_hi (hit_gain_hi),
      .hit_gain_lo (hit_gain_lo)
   );

   assign any_hit = hit_ofs_hi | hit_ofs_lo | hit_gain_hi | hit_gain_lo;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction : merge16

   // *****************************
   // next state
   // *****************************
   always_comb begin
      s_nxt = s_r;
      case (s_r.st)
         CCR_IDLE: begin
            s_nxt.wreq = 1'b1;
            if (avs_read || avs_write) begin
               s_nxt.st     = CCR_RESP;
               s_nxt.wreq   = 1'b0;
               s_nxt.resp   = any_hit ? 2'h0 : 2'h3;
               s_nxt.rdata  = 32'h0000_0000;
               if (avs_write) begin
                  if (hit_ofs_hi)
                     s_nxt.trim.ofs_hi = merge16(s_r.trim.ofs_hi, avs_writedata,
                                                 avs_byteenable);
                  if (hit_gain_hi)
                     s_nxt.trim.gain_hi = merge16(s_r.trim.gain_hi, avs_writedata,
                                                  avs_byteenable);
                  if (hit_ofs_lo && avs_byteenable[1])
                     s_nxt.trim.ofs_lo = avs_writedata[`CCR_LO_FIELD_MSB:`CCR_LO_FIELD_LSB];
                  if (hit_gain_lo && avs_byteenable[1])
                     s_nxt.trim.gain_lo = avs_writedata[`CCR_LO_FIELD_MSB:`CCR_LO_FIELD_LSB];
               end else begin
                  if (hit_ofs_hi)
                     s_nxt.rdata = {16'h0000, s_r.trim.ofs_hi};
                  if (hit_ofs_lo)
                     s_nxt.rdata = {16'h0000, s_r.trim.ofs_lo, 8'h00};
                  if (hit_gain_hi)
                     s_nxt.rdata = {16'h0000, s_r.trim.gain_hi};
                  if (hit_gain_lo)
                     s_nxt.rdata = {16'h0000, s_r.trim.gain_lo, 8'h00};
               end
            end
         end
         CCR_RESP: begin
            // answer shown this cycle; master releases at this edge
            s_nxt.st    = CCR_HOLD;
            s_nxt.wreq  = 1'b1;
            s_nxt.rdata = 32'h0000_0000;
            s_nxt.resp  = 2'h0;
         end
         CCR_HOLD: begin
            // one idle cycle so a held request is not taken twice
            s_nxt.st = CCR_IDLE;
         end
         default: begin
            s_nxt.st   = CCR_IDLE;
            s_nxt.wreq = 1'b1;
         end
      endcase
   end

   // *****************************
   // registers
   // *****************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r.st           <= CCR_IDLE;
         s_r.trim.ofs_hi  <= `CCR_RST_OFS_HI;
         s_r.trim.ofs_lo  <= `CCR_RST_OFS_LO;
         s_r.trim.gain_hi <= `CCR_RST_GAIN_HI;
         s_r.trim.gain_lo <= `CCR_RST_GAIN_LO;
         s_r.rdata        <= 32'h0000_0000;
         s_r.resp         <= 2'h0;
         s_r.wreq         <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // *****************************
   // outputs
   // *****************************
   assign avs_readdata    = s_r.rdata;
   assign avs_waitrequest = s_r.wreq;
   assign avs_response    = s_r.resp;
   assign offset_trim     = {s_r.trim.ofs_hi, s_r.trim.ofs_lo};
   assign gain_trim       = {s_r.trim.gain_hi, s_r.trim.gain_lo};

   // *****************************
   // checks
   // *****************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   lo_ofs_zero_a: assert property (
      !avs_waitrequest && avs_read && hit_ofs_lo |-> avs_readdata[7:0] == 8'h00)
      else $error("offset low byte not zero");
   lo_gain_zero_a: assert property (
      !avs_waitrequest && avs_read && hit_gain_lo |-> avs_readdata[7:0] == 8'h00)
      else $error("gain low byte not zero");
   ofs_hi_wr_a: assert property (
      $fell(s_r.wreq) && $past(avs_write && hit_ofs_hi && avs_byteenable == 4'hf)
      |-> offset_trim[23:8] == $past(avs_writedata[15:0]))
      else $error("offset high write lost");
   gain_hi_wr_a: assert property (
      $fell(s_r.wreq) && $past(avs_write && hit_gain_hi && avs_byteenable == 4'hf)
      |-> gain_trim[23:8] == $past(avs_writedata[15:0]))
      else $error("gain high write lost");
   ofs_hi_part_a: assert property (
      $fell(s_r.wreq) && $past(avs_write && hit_ofs_hi && avs_byteenable[1:0] == 2'b10)
      |-> offset_trim[23:8] == {$past(avs_writedata[15:8]), $past(offset_trim[15:8])})
      else $error("offset high lane merge wrong");
   gain_hi_part_a: assert property (
      $fell(s_r.wreq) && $past(avs_write && hit_gain_hi && avs_byteenable[1:0] == 2'b01)
      |-> gain_trim[23:8] == {$past(gain_trim[23:16]), $past(avs_writedata[7:0])})
      else $error("gain high lane merge wrong");
   ofs_lo_wr_a: assert property (
      $fell(s_r.wreq) && $past(avs_write && hit_ofs_lo && avs_byteenable[1])
      |-> offset_trim[7:0] == $past(avs_writedata[15:8]))
      else $error("offset low write lost");
   gain_lo_wr_a: assert property (
      $fell(s_r.wreq) && $past(avs_write && hit_gain_lo && avs_byteenable[1])
      |-> gain_trim[7:0] == $past(avs_writedata[15:8]))
      else $error("gain low write lost");
   ofs_lo_ign_a: assert property (
      $fell(s_r.wreq) && $past(avs_write && hit_ofs_lo && !avs_byteenable[1])
      |-> $stable(offset_trim))
      else $error("offset low changed");
   gain_lo_ign_a: assert property (
      $fell(s_r.wreq) && $past(avs_write && hit_gain_lo && !avs_byteenable[1])
      |-> $stable(gain_trim))
      else $error("gain low changed");
   trim_hold_a: assert property (
      !$past(avs_write && s_r.st == CCR_IDLE) |-> $stable(offset_trim) && $stable(gain_trim))
      else $error("trim changed without a write");
   reset_gain_a: assert property (
      $rose(rst_n) |-> gain_trim == 24'h80_0000)
      else $error("gain reset value wrong");
   reset_ofs_a: assert property (
      $rose(rst_n) |-> offset_trim == 24'h00_0000)
      else $error("offset reset value wrong");
   ofs_read_a: assert property (
      !avs_waitrequest && $past(avs_read && hit_ofs_hi)
      |-> avs_readdata == {16'h0000, offset_trim[23:8]})
      else $error("offset high read mismatch");
   ofs_lo_read_a: assert property (
      !avs_waitrequest && $past(avs_read && hit_ofs_lo)
      |-> avs_readdata == {16'h0000, offset_trim[7:0], 8'h00})
      else $error("offset low read mismatch");
   gain_read_a: assert property (
      !avs_waitrequest && $past(avs_read && hit_gain_hi)
      |-> avs_readdata == {16'h0000, gain_trim[23:16], gain_trim[15:8]})
      else $error("gain read mismatch");
   gain_lo_read_a: assert property (
      !avs_waitrequest && $past(avs_read && hit_gain_lo)
      |-> avs_readdata == {16'h0000, gain_trim[7:0], 8'h00})
      else $error("gain low read mismatch");
   resp_ok_a: assert property (
      !avs_waitrequest && $past(any_hit) |-> avs_response == 2'h0)
      else $error("mapped access not answered okay");
   unmapped_resp_a: assert property (
      !avs_waitrequest && $past(!any_hit) |-> avs_response == 2'h3 && avs_readdata == 32'h0000_0000)
      else $error("unmapped access answer wrong");
   idle_quiet_a: assert property (
      avs_waitrequest |-> avs_readdata == 32'h0000_0000 && avs_response == 2'h0)
      else $error("answer shown while waiting");
   wait_once_a: assert property (
      !avs_waitrequest |=> avs_waitrequest [*2])
      else $error("waitrequest low too long");

   // *****************************
   // cover points
   // *****************************
   wr_ofs_c: cover property (avs_write && hit_ofs_hi && !avs_waitrequest);
   rd_gain_c: cover property (avs_read && hit_gain_lo && !avs_waitrequest);
   unmapped_c: cover property (!avs_waitrequest && avs_response == 2'h3);
   lo_ign_c: cover property (avs_write && hit_gain_lo && !avs_byteenable[1] && !avs_waitrequest);
   part_c: cover property (avs_write && hit_ofs_hi && avs_byteenable[1:0] == 2'b10
      && !avs_waitrequest);
endmodule : ccr_regs
`default_nettype wire

/* design/ccr_params.svh */
/*
 channel calibration register map: offsets, field positions, reset values.
 assumes inclusion by bare name from design files only.
*/
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH
// *****************************
// register indices (byte addr = 4 * index)
// *****************************
`define CCR_IDX_OFS_HI      8'h19
`define CCR_IDX_OFS_LO      8'h1a
`define CCR_IDX_GAIN_HI     8'h1b
`define CCR_IDX_GAIN_LO     8'h1c
// *****************************
// field positions and reset values
// *****************************
`define CCR_HI_MSB          15
`define CCR_LO_FIELD_MSB    15
`define CCR_LO_FIELD_LSB    8
`define CCR_RST_OFS_HI      16'h0000
`define CCR_RST_OFS_LO      8'h00
`define CCR_RST_GAIN_HI     16'h8000
`define CCR_RST_GAIN_LO     8'h00
`define CCR_RD_LATENCY      1
`endif

/* design/ccr_pkg.sv */
/*
 types for the channel calibration register bank.
 assumes nothing of its surroundings.
*/
`default_nettype none
package ccr_pkg;
   typedef enum logic [2:0] {
      CCR_IDLE = 3'b001,
      CCR_RESP = 3'b010,
      CCR_HOLD = 3'b100
   } ccr_state_t;

   typedef struct packed {
      logic [15:0] ofs_hi;
      logic [7:0]  ofs_lo;
      logic [15:0] gain_hi;
      logic [7:0]  gain_lo;
   } ccr_trim_t;
endpackage : ccr_pkg
`default_nettype wire

/* design/ccr_decode.sv */
/*
 address decoder: maps an avalon byte address to one of the four registers.
 assumes word-aligned 32-bit accesses with an 8-bit byte address.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ccr_params.svh"
module ccr_decode (
   input  wire logic [7:0] address,
   output logic            hit_ofs_hi,
   output logic            hit_ofs_lo,
   output logic            hit_gain_hi,
   output logic            hit_gain_lo
);
   function automatic logic idx_hit(input logic [7:0] a, input logic [7:0] idx);
      idx_hit = (a[1:0] == 2'h0) && (a[7:2] == idx[5:0]);
   endfunction : idx_hit

   always_comb begin
      hit_ofs_hi  = idx_hit(address, `CCR_IDX_OFS_HI);
      hit_ofs_lo  = idx_hit(address, `CCR_IDX_OFS_LO);
      hit_gain_hi = idx_hit(address, `CCR_IDX_GAIN_HI);
      hit_gain_lo = idx_hit(address, `CCR_IDX_GAIN_LO);
   end
endmodule : ccr_decode
`default_nettype wire

/* dv/testbench.sv */
/*
 self-checking bench for the channel calibration register bank.
 assumes ccr_regs as the design top, one 100 MHz clock, avalon-mm access.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ************
   // signals
   // ************
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0]  avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [1:0]  avs_response;
   logic [23:0] offset_trim;
   logic [23:0] gain_trim;
   logic [31:0] rd;
   logic [1:0]  rsp;
   int          fail_count = 0;
   int          checks = 0;
   int          cycles = 0;
   localparam logic [7:0] A_OH = 8'h64;
   localparam logic [7:0] A_OL = 8'h68;
   localparam logic [7:0] A_GH = 8'h6c;
   localparam logic [7:0] A_GL = 8'h70;

   ccr_regs dut_u (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .offset_trim,
      .gain_trim);

   always #5 sys_clk = ~sys_clk;

   // hang guard
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         results();
      end
   end
   // ************
   // bus and compare tasks
   // ************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // request held until the edge that sees waitrequest low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= ~wr;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      rsp = avs_response;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      bus(1'b1, a, d, be);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, 4'hf);
      chk(rd, exp);
      chk({30'h0000_0000, rsp}, 32'h0000_0000);
   endtask : rdchk
   // ************
   // scenarios
   // ************
   task automatic apply_reset();
      rst_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
   endtask : apply_reset

   task automatic reset_values();
      rdchk(A_OH, 32'h0000_0000);
      rdchk(A_OL, 32'h0000_0000);
      rdchk(A_GH, 32'h0000_8000);
      rdchk(A_GL, 32'h0000_0000);
      chk({8'h00, gain_trim}, 32'h0080_0000);
      chk({8'h00, offset_trim}, 32'h0000_0000);
   endtask : reset_values

   // negative offset, reserved byte written with ones
   task automatic offset_fields();
      wr(A_OH, 32'h0000_8001, 4'hf);
      wr(A_OL, 32'h0000_a5ff, 4'hf);
      rdchk(A_OH, 32'h0000_8001);
      rdchk(A_OL, 32'h0000_a500);
      chk({8'h00, offset_trim}, 32'h0080_01a5);
      wr(A_OL, 32'h0000_003c, 4'h1);
      rdchk(A_OL, 32'h0000_a500);
      wr(A_OH, 32'h0000_7fee, 4'h2);
      rdchk(A_OH, 32'h0000_7f01);
   endtask : offset_fields

   // gain at full scale, then smallest step with lane1 only
   task automatic gain_fields();
      wr(A_GH, 32'h0000_ffff, 4'hf);
      wr(A_GL, 32'h0000_ffff, 4'hf);
      chk({8'h00, gain_trim}, 32'h00ff_ffff);
      rdchk(A_GL, 32'h0000_ff00);
      wr(A_GH, 32'h0000_0000, 4'hf);
      wr(A_GL, 32'h0000_0100, 4'h2);
      chk({8'h00, gain_trim}, 32'h0000_0001);
      rdchk(A_GH, 32'h0000_0000);
      wr(A_GH, 32'h0000_4321, 4'h1);
      rdchk(A_GH, 32'h0000_0021);
      wr(A_GL, 32'h0000_00ff, 4'h1);
      rdchk(A_GL, 32'h0000_0100);
      chk({8'h00, gain_trim}, 32'h0000_2101);
   endtask : gain_fields

   // unmapped and unaligned places change nothing
   task automatic unmapped();
      bus(1'b0, 8'h74, 32'h0000_0000, 4'hf);
      chk(rd, 32'h0000_0000);
      chk({30'h0000_0000, rsp}, 32'h0000_0003);
      wr(8'h65, 32'h0000_ffff, 4'hf);
      chk({8'h00, offset_trim}, 32'h007f_01a5);
   endtask : unmapped

   task automatic results();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   initial begin
      apply_reset();
      reset_values();
      offset_fields();
      gain_fields();
      unmapped();
      apply_reset();
      reset_values();
      results();
   end
endmodule : testbench
`default_nettype wire
